// ===== design/acg_params.svh
// Constants of the converter channel, clock and trigger glue.
// Assumes inclusion by the package and the design module only.
`ifndef ACG_PARAMS_SVH
`define ACG_PARAMS_SVH

`define ACG_CH_LAST_PIN   5'h0B
`define ACG_CH_GND_FIRST  5'h0C
`define ACG_CH_GND_LAST   5'h14
`define ACG_CH_TEMP       5'h1A
`define ACG_CH_BANDGAP    5'h1B
`define ACG_CH_VREFH      5'h1D
`define ACG_CH_VREFL      5'h1E
`define ACG_CH_OFF        5'h1F
`define ACG_RES_BITS      10
`define ACG_SAMPLE_SHORT  4'h3
`define ACG_SAMPLE_LONG   4'hF

`endif

// ===== design/acg_pkg.sv
// Types of the converter channel, clock and trigger glue.
// Assumes the params header sits beside it.
`include "acg_params.svh"
package acg_pkg;
   typedef enum logic [1:0] {ACG_SRC_BUS, ACG_SRC_BUS2, ACG_SRC_LOCAL,
                             ACG_SRC_ALT} acg_src_e;
   typedef enum logic [2:0] {ACG_IN_NONE, ACG_IN_PIN, ACG_IN_GND,
                             ACG_IN_TEMP, ACG_IN_BG, ACG_IN_VREFH,
                             ACG_IN_VREFL} acg_in_e;
   typedef struct packed
   {
      logic [4:0] channelSelectField;
      logic       continuous;
      logic       convIrqEnable;
      logic       hwTrigEnable;
      logic       compareEnable;
      logic       compareGreaterEq;
      logic       mode8;
      logic       longSample;
      acg_src_e   clockSource;
      logic [1:0] clockDivideField;
   } acg_ctrl_s;
   typedef struct packed
   {
      acg_in_e    inputKind;
      logic [3:0] pinIndex;
      logic       powered;
   } acg_mux_s;
endpackage

// ===== design/acg_glue.sv
// Channel decode, clock selection, trigger and SAR sequencing.
// Assumes one 200 MHz clock; slow clocks arrive as enable pulses.
`timescale 1ns/1ps
`default_nettype none
`include "acg_params.svh"
module acg_glue
(
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   input  wire acg_pkg::acg_ctrl_s ctrl,
   input  wire logic              ctrlWrite,
   input  wire logic [9:0]        compareValue,
   input  wire logic              localAsyncTick,
   input  wire logic              extReferenceTick,
   input  wire logic              counterOverflow,
   input  wire logic              compHigher,
   input  wire logic              resultRead,
   input  wire logic              flagClear,
   output var acg_pkg::acg_mux_s  muxSel,
   output logic                   convActive,
   output logic                   convComplete,
   output logic                   convIrq,
   output logic [9:0]             result,
   output logic                   sampleHold,
   output logic [9:0]             dacCode
);
   import acg_pkg::*;

   typedef enum logic [1:0] {ACG_IDLE, ACG_SAMPLE, ACG_CONVERT} acg_state_e;

   // =====================================================================
   // Channel decode
   acg_mux_s   muxNext;
   always_comb
   begin
      muxNext.pinIndex  = ctrl.channelSelectField[3:0];
      muxNext.powered   = 1'b1;
      muxNext.inputKind = ACG_IN_NONE;
      if (ctrl.channelSelectField <= `ACG_CH_LAST_PIN)
         muxNext.inputKind = ACG_IN_PIN;
      else if (ctrl.channelSelectField <= `ACG_CH_GND_LAST)
         muxNext.inputKind = ACG_IN_GND;
      else if (ctrl.channelSelectField == `ACG_CH_TEMP)
         muxNext.inputKind = ACG_IN_TEMP;
      else if (ctrl.channelSelectField == `ACG_CH_BANDGAP)
         muxNext.inputKind = ACG_IN_BG;
      else if (ctrl.channelSelectField == `ACG_CH_VREFH)
         muxNext.inputKind = ACG_IN_VREFH;
      else if (ctrl.channelSelectField == `ACG_CH_VREFL)
         muxNext.inputKind = ACG_IN_VREFL;
      else if (ctrl.channelSelectField == `ACG_CH_OFF)
         muxNext.powered = 1'b0;
      if (muxNext.inputKind != ACG_IN_PIN)
         muxNext.pinIndex = 4'h0;
   end

   // =====================================================================
   // Conversion clock: source select then divide
   // Alternate source is the external reference tick, gated by nothing,
   // so it keeps counting through wait mode.
   logic       busHalf_reg;
   logic       busHalf_next;
   logic [2:0] divCnt_reg;
   logic [2:0] divCnt_next;
   logic       srcTick;
   logic       convTick_reg;
   logic       convTick_next;
   logic [2:0] divLast;
   always_comb
   begin
      busHalf_next = ~busHalf_reg;
      unique case (ctrl.clockSource)
         ACG_SRC_BUS:   srcTick = 1'b1;
         ACG_SRC_BUS2:  srcTick = busHalf_reg;
         ACG_SRC_LOCAL: srcTick = localAsyncTick;
         ACG_SRC_ALT:   srcTick = extReferenceTick;
      endcase
      divLast       = 3'((4'h1 << ctrl.clockDivideField) - 4'h1);
      divCnt_next   = divCnt_reg;
      convTick_next = 1'b0;
      if (srcTick)
      begin
         if (divCnt_reg >= divLast)
         begin
            divCnt_next   = 3'h0;
            convTick_next = 1'b1;
         end
         else
            divCnt_next = divCnt_reg + 3'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         busHalf_reg  <= 1'b0;
         divCnt_reg   <= 3'h0;
         convTick_reg <= 1'b0;
      end
      else
      begin
         busHalf_reg  <= busHalf_next;
         divCnt_reg   <= divCnt_next;
         convTick_reg <= convTick_next;
      end
   end

   // =====================================================================
   // Sequencer
   // Trigger pulse ignores the counter's own interrupt enable and is not
   // gated by power mode, so it starts conversions in run, wait, stop3.
   acg_state_e state_reg;
   acg_state_e state_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [9:0] sar_reg;
   logic [9:0] sar_next;
   logic [9:0] result_next;
   logic       complete_next;
   logic       armed_reg;
   logic       armed_next;
   logic       hwStart;
   logic       swStart;
   logic       compareTrue;
   logic [9:0] trialBit;
   logic [9:0] finalCode;
   logic [9:0] finalCmp;
   logic       off;
   always_comb
   begin
      off       = ctrl.channelSelectField == `ACG_CH_OFF;
      hwStart   = ctrl.hwTrigEnable & counterOverflow & ~off;
      swStart   = ctrlWrite & ~ctrl.hwTrigEnable & ~off;
      trialBit  = 10'h200 >> cnt_reg;
      finalCode = compHigher ? sar_reg : (sar_reg & ~trialBit);
      finalCmp  = ctrl.mode8 ? {2'h0, finalCode[9:2]} : finalCode;
      compareTrue = ctrl.compareGreaterEq ? (finalCmp >= compareValue)
                                          : (finalCmp < compareValue);
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      sar_next      = sar_reg;
      result_next   = result;
      complete_next = convComplete;
      armed_next    = armed_reg;
      if (ctrlWrite)
      begin
         complete_next = 1'b0;
         armed_next    = ctrl.hwTrigEnable & ctrl.continuous;
      end
      else if (resultRead || flagClear)
         complete_next = 1'b0;
      if (ctrlWrite || off)
         state_next = ACG_IDLE;
      if (swStart || (hwStart && (state_reg == ACG_IDLE || ctrlWrite)))
      begin
         state_next = ACG_SAMPLE;
         cnt_next   = ctrl.longSample ? `ACG_SAMPLE_LONG : `ACG_SAMPLE_SHORT;
         sar_next   = 10'h200;
      end
      else if (!ctrlWrite && !off && convTick_reg)
      begin
         unique case (state_reg)
            ACG_IDLE: ;
            ACG_SAMPLE:
               if (cnt_reg == 4'h0)
                  state_next = ACG_CONVERT;
               else
                  cnt_next = cnt_reg - 4'h1;
            ACG_CONVERT:
            begin
               if (cnt_reg == 4'(`ACG_RES_BITS - 1))
               begin
                  result_next = finalCmp;
                  if (!ctrl.compareEnable || compareTrue)
                     complete_next = 1'b1;
                  cnt_next = ctrl.longSample ? `ACG_SAMPLE_LONG
                                             : `ACG_SAMPLE_SHORT;
                  sar_next = 10'h200;
                  if (ctrl.continuous && !ctrl.hwTrigEnable)
                     state_next = ACG_SAMPLE;
                  else
                     state_next = ACG_IDLE;
               end
               else
               begin
                  sar_next = (compHigher ? sar_reg : (sar_reg & ~trialBit))
                           | (trialBit >> 1);
                  cnt_next = cnt_reg + 4'h1;
               end
            end
            default: state_next = ACG_IDLE;
         endcase
      end
      if (state_reg == ACG_SAMPLE && state_next == ACG_CONVERT)
         cnt_next = 4'h0;
   end
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg    <= ACG_IDLE;
         cnt_reg      <= 4'h0;
         sar_reg      <= 10'h000;
         result       <= 10'h000;
         convComplete <= 1'b0;
         armed_reg    <= 1'b0;
         muxSel       <= '{ACG_IN_NONE, 4'h0, 1'b0};
         convActive   <= 1'b0;
         convIrq      <= 1'b0;
         sampleHold   <= 1'b0;
         dacCode      <= 10'h000;
      end
      else
      begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         sar_reg      <= sar_next;
         result       <= result_next;
         convComplete <= complete_next;
         armed_reg    <= armed_next;
         muxSel       <= muxNext;
         convActive   <= state_next != ACG_IDLE;
         convIrq      <= complete_next & ctrl.convIrqEnable;
         sampleHold   <= state_next == ACG_SAMPLE;
         dacCode      <= sar_next;
      end
   end

   // =====================================================================
   // Checks
   a_off_isolates: assert property (@(posedge clk_sys) disable iff (!resetn)
      ctrl.channelSelectField == `ACG_CH_OFF |=> !muxSel.powered
      && muxSel.inputKind == ACG_IN_NONE) else $error("off not isolated");
   a_pin_route: assert property (@(posedge clk_sys) disable iff (!resetn)
      ctrl.channelSelectField <= `ACG_CH_LAST_PIN |=> muxSel.inputKind
      == ACG_IN_PIN && muxSel.pinIndex == $past(ctrl.channelSelectField[3:0]))
      else $error("pin route wrong");
   a_temp_route: assert property (@(posedge clk_sys) disable iff (!resetn)
      ctrl.channelSelectField == `ACG_CH_TEMP |=> muxSel.inputKind
      == ACG_IN_TEMP) else $error("temp route wrong");
   a_bg_route: assert property (@(posedge clk_sys) disable iff (!resetn)
      ctrl.channelSelectField == `ACG_CH_BANDGAP |=> muxSel.inputKind
      == ACG_IN_BG) else $error("bandgap route wrong");
   a_hw_start: assert property (@(posedge clk_sys) disable iff (!resetn)
      hwStart && !convActive |=> convActive && sampleHold)
      else $error("overflow did not start");
   a_write_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
      ctrlWrite && !ctrl.hwTrigEnable && !off |=> sampleHold && !convComplete)
      else $error("write did not restart");
   a_irq_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
      convIrq |-> convComplete) else $error("irq without flag");
   a_res_format: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(result) && ctrl.mode8 && $stable(ctrl.mode8)
      |-> result[9:8] == 2'h0) else $error("8-bit result not justified");

   // =====================================================================
   // Checks: remaining decode codes
   a_gnd_route: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ctrl.channelSelectField >= `ACG_CH_GND_FIRST
      && ctrl.channelSelectField <= `ACG_CH_GND_LAST
      |=> muxSel.inputKind == ACG_IN_GND)
      else $error("ground route wrong");

   a_vrefh_route: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ctrl.channelSelectField == `ACG_CH_VREFH
      |=> muxSel.inputKind == ACG_IN_VREFH)
      else $error("high reference route wrong");

   a_vrefl_route: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ctrl.channelSelectField == `ACG_CH_VREFL
      |=> muxSel.inputKind == ACG_IN_VREFL)
      else $error("low reference route wrong");

   // Reserved codes must leave the input floating, not grounded
   a_rsvd_none: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (ctrl.channelSelectField inside {[5'h15:5'h19], 5'h1C})
      |=> muxSel.inputKind == ACG_IN_NONE && muxSel.powered
      && muxSel.pinIndex == 4'h0)
      else $error("reserved code connected");

   a_pin_index: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      muxSel.inputKind != ACG_IN_PIN |-> muxSel.pinIndex == 4'h0)
      else $error("stray pin index");

   // =====================================================================
   // Checks: clock selection
   a_alt_tick: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ctrl.clockSource == ACG_SRC_ALT |-> srcTick == extReferenceTick)
      else $error("alternate tick not reference");

   a_tick_source: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      convTick_reg |-> $past(srcTick))
      else $error("tick without source edge");

   // =====================================================================
   // Checks: sequencing and flags
   a_off_idle: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      off |=> !convActive && !sampleHold)
      else $error("off channel still converting");

   a_hw_no_sw: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ctrlWrite && ctrl.hwTrigEnable && !counterOverflow |=> !convActive)
      else $error("write started hardware mode");

   a_write_clears: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ctrlWrite |=> !convComplete)
      else $error("write left flag set");

   a_idle_clear: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (resultRead || flagClear) && !convActive |=> !convComplete)
      else $error("clear ignored");

   a_irq_follow: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      convIrq == (convComplete && $past(ctrl.convIrqEnable)))
      else $error("irq does not follow flag");

   a_single_idle: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      $rose(convComplete) && !$past(ctrl.continuous) |-> !convActive)
      else $error("single conversion not idle");

   a_start_active: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      $rose(sampleHold) |-> convActive)
      else $error("sampling while inactive");

   // Trial code must rest at midscale for the whole sample phase
   a_sample_dac: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      sampleHold |-> dacCode == 10'h200)
      else $error("trial code moved while sampling");
endmodule
`default_nettype wire

// ===== verif/acg_partner.sv
// Partner model: analog input mux levels and periodic tick counter.
// Assumes the converter compares level against dacCode each tick.
`timescale 1ns/1ps
`default_nettype none
module acg_partner
   import acg_pkg::*;
#(
   parameter logic [9:0] TEMP_LVL = 10'h1A5,
   parameter logic [9:0] BG_LVL   = 10'h2E0,
   parameter int         PERIOD   = 40
)
(
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   input  wire acg_pkg::acg_mux_s muxSel,
   input  wire logic [9:0]        dacCode,
   input  wire logic [9:0]        pinLevel,
   input  wire logic              trigEn,
   output logic                   compHigher,
   output logic                   counterOverflow
);
   // ==========================================================
   // Analog level
   logic [9:0] level;
   logic       flip;
   logic [7:0] cnt;
   always_comb
   begin
      case (muxSel.inputKind)
         ACG_IN_PIN:   level = pinLevel;
         ACG_IN_GND:   level = 10'h000;
         ACG_IN_VREFH: level = 10'h3FF;
         ACG_IN_TEMP:  level = TEMP_LVL;
         ACG_IN_BG:    level = BG_LVL;
         default:      level = 10'h000;
      endcase
   end
   // Nothing connected: comparator wanders, never settles
   assign compHigher = (muxSel.inputKind == ACG_IN_NONE || !muxSel.powered)
                       ? flip : (level >= dacCode);
   // ==========================================================
   // Periodic counter; no interrupt enable gates it
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt <= 8'h00;
         flip <= 1'b0;
         counterOverflow <= 1'b0;
      end
      else
      begin
         flip <= !flip;
         cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
         counterOverflow <= trigEn && (cnt == 8'(PERIOD - 1));
      end
   end
endmodule
`default_nettype wire

// ===== verif/adc_channel_clock_trigger_glue_tb_top.sv
// Self-checking bench of the channel, clock and trigger glue.
// Assumes the partner model supplies comparator and overflow.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_clock_trigger_glue_tb_top;
   import acg_pkg::*;
   localparam logic [9:0] TEMP_LVL = 10'h1A5;
   localparam logic [9:0] BG_LVL   = 10'h2E0;
   logic      clk_sys = 0, resetn = 0, ctrlWrite = 0, trigEn = 0;
   logic      localAsyncTick = 0, extReferenceTick = 0;
   logic      resultRead = 0, flagClear = 0;
   acg_ctrl_s ctrl = '0;
   acg_ctrl_s c;
   logic [9:0] compareValue = '0, pinLevel = '0, result, dacCode, lvl;
   acg_mux_s  muxSel;
   logic      convActive, convComplete, convIrq, sampleHold;
   logic      compHigher, counterOverflow;
   int        fails = 0, compares = 0, k, n;
   acg_glue dut (.clk_sys(clk_sys), .resetn(resetn), .ctrl(ctrl),
      .ctrlWrite(ctrlWrite), .compareValue(compareValue),
      .localAsyncTick(localAsyncTick), .extReferenceTick(extReferenceTick),
      .counterOverflow(counterOverflow), .compHigher(compHigher),
      .resultRead(resultRead), .flagClear(flagClear), .muxSel(muxSel),
      .convActive(convActive), .convComplete(convComplete),
      .convIrq(convIrq), .result(result), .sampleHold(sampleHold),
      .dacCode(dacCode));
   acg_partner #(.TEMP_LVL(TEMP_LVL), .BG_LVL(BG_LVL), .PERIOD(40)) far
      (.clk_sys(clk_sys), .resetn(resetn), .muxSel(muxSel),
       .dacCode(dacCode), .pinLevel(pinLevel), .trigEn(trigEn),
       .compHigher(compHigher), .counterOverflow(counterOverflow));
   initial
   begin
      forever #2.5 clk_sys = !clk_sys;
   end
   // Slow clock edges arrive at random, like unrelated sources
   always @(posedge clk_sys)
   begin
      localAsyncTick <= 1'($urandom);
      extReferenceTick <= 1'($urandom);
   end
   // ==========================================================
   // Expectations
   function automatic acg_in_e expKind(logic [4:0] ch);
      if (ch <= 5'h0B) return ACG_IN_PIN;
      if (ch <= 5'h14) return ACG_IN_GND;
      case (ch)
         5'h1A:   return ACG_IN_TEMP;
         5'h1B:   return ACG_IN_BG;
         5'h1D:   return ACG_IN_VREFH;
         5'h1E:   return ACG_IN_VREFL;
         default: return ACG_IN_NONE;
      endcase
   endfunction
   function automatic logic [9:0] expLvl(logic [4:0] ch, logic [9:0] p);
      if (ch <= 5'h0B) return p;
      if (ch == 5'h1D) return 10'h3FF;
      if (ch == 5'h1A) return TEMP_LVL;
      if (ch == 5'h1B) return BG_LVL;
      return 10'h000;
   endfunction
   // ==========================================================
   // Shared tasks
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Write control, then wait until the conversion has gone idle
   task automatic conv(acg_ctrl_s cv);
      int i;
      @(posedge clk_sys);
      ctrl <= cv;
      ctrlWrite <= 1'b1;
      @(posedge clk_sys);
      ctrlWrite <= 1'b0;
      for (i = 0; i < 3000; i++)
      begin
         #1;
         if (i > 0 && convActive !== 1'b1) break;
         @(posedge clk_sys);
      end
      if (i == 3000)
      begin
         fails++;
         summarize();
      end
   endtask
   task automatic pulseClear(logic viaRead);
      @(posedge clk_sys);
      resultRead <= viaRead;
      flagClear <= !viaRead;
      @(posedge clk_sys);
      {resultRead, flagClear} <= 2'b00;
      @(posedge clk_sys);
      #1;
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h944e));
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      for (k = 0; k < 32; k++)
      begin
         c = '0;
         c.channelSelectField = 5'(k);
         c.hwTrigEnable = 1'b1;
         @(posedge clk_sys);
         ctrl <= c;
         repeat (2) @(posedge clk_sys);
         #1;
         check("kind", 16'(expKind(5'(k))), 16'(muxSel.inputKind));
         check("powered", 16'(k != 31), 16'(muxSel.powered));
         if (k < 12) check("pin", 16'(k), 16'(muxSel.pinIndex));
      end
      for (n = 0; n < 40; n++)
      begin
         c = acg_ctrl_s'(16'($urandom));
         k = $urandom % 32;
         if (k inside {[21:25], 28, 31}) k = n % 12;
         c.channelSelectField = 5'(k);
         {c.continuous, c.hwTrigEnable, c.compareEnable} = 3'b000;
         c.clockSource = acg_src_e'(n % 4); // Run mode only
         pinLevel <= 10'($urandom);
         conv(c);
         lvl = expLvl(5'(k), pinLevel);
         check("result", c.mode8 ? 16'(lvl >> 2) : 16'(lvl), 16'(result));
         check("done", 16'h0001, 16'(convComplete));
         check("irq", 16'(c.convIrqEnable), 16'(convIrq));
         check("idle", 16'h0000, 16'(convActive));
         pulseClear(n[0]);
         check("cleared", 16'h0000, 16'({convComplete, convIrq}));
      end
      // Restart in mid-conversion takes the new input
      c.channelSelectField = 5'h03;
      c.mode8 = 1'b0;
      pinLevel <= 10'h155;
      @(posedge clk_sys);
      ctrl <= c;
      ctrlWrite <= 1'b1;
      @(posedge clk_sys);
      ctrlWrite <= 1'b0;
      #1;
      check("sample", 16'h0001, 16'(sampleHold));
      check("dac", 16'h0200, 16'(dacCode));
      repeat (6) @(posedge clk_sys);
      pinLevel <= 10'h2AA;
      conv(c);
      check("restart", 16'h02AA, 16'(result));
      // Compare gates the flag: 0x0C8 against 0x12C
      c.compareEnable = 1'b1;
      compareValue <= 10'h12C;
      pinLevel <= 10'h0C8;
      for (k = 0; k < 2; k++)
      begin
         c.compareGreaterEq = 1'(k);
         conv(c);
         check("compare", 16'(k == 0), 16'(convComplete));
         pulseClear(1'b0);
      end
      // Continuous run stopped by the all-ones channel
      c.compareEnable = 1'b0;
      c.continuous = 1'b1;
      @(posedge clk_sys);
      ctrl <= c;
      ctrlWrite <= 1'b1;
      @(posedge clk_sys);
      ctrlWrite <= 1'b0;
      repeat (20) @(posedge clk_sys);
      c.channelSelectField = 5'h1F;
      conv(c);
      repeat (3) @(posedge clk_sys);
      #1;
      check("off", 16'h0000, 16'({convActive, muxSel.powered}));
      // Hardware trigger: write does not start, overflow does
      c.channelSelectField = 5'h05;
      {c.continuous, c.hwTrigEnable} = 2'b01;
      pinLevel <= 10'h3C3;
      conv(c);
      check("no sw", 16'h0000, 16'(convComplete));
      trigEn <= 1'b1;
      for (k = 0; k < 3000 && convComplete !== 1'b1; k++)
      begin
         @(posedge clk_sys);
         #1;
      end
      trigEn <= 1'b0;
      #1;
      check("hw done", 16'h0001, 16'(convComplete));
      check("hw res", c.mode8 ? 16'h00F0 : 16'h03C3, 16'(result));
      summarize();
   end
endmodule
`default_nettype wire
